//--- dpll_lock_detect_config_tb.sv
// dpll_lock_detect_config_tb: register and lock-path tests of the lock detector.
// assumes SUB_CYC of 4, so one second is 256 cycles and lock takes 512.
`timescale 1ns/1ns
module dpll_lock_detect_config_tb;
    import dpllc_pkg::*;
    logic               clk = 1'b0, rst_b = 1'b0, new_ref = 1'b0, run = 1'b0, over = 1'b0, at = 1'b0;
    logic               edge_w, lol, lkd, alarm, mcen, frz;
    dpllc_req_t         req = '0;
    logic [7:0]         rdata;
    logic signed [23:0] perr = '0, current_frequency_value = 24'sh000123, lphase, fread;
    logic [8:0]         bw;
    dpllc_det_t         det;
    logic [7:0]         ra [5] = '{8'h75, 8'h76, 8'h79, 8'h7A, 8'h77};
    logic [7:0]         rv [5] = '{8'h70, 8'hE0, 8'h25, 8'h32, 8'h00};
    int                 err_count = 0, checks = 0, n;

    dpllc_ref_model REF (.core_clk_i(clk), .run_i(run), .period_i(16'h0010), .ref_edge_o(edge_w));
    dpllc_lock_detect #(.SUB_CYC(4)) DUT (.core_clk_i(clk), .rst_b_i(rst_b), .reg_req_i(req),
        .reg_rdata_o(rdata), .new_ref_i(new_ref), .ref_edge_i(edge_w), .ref_period_cyc_i(16'h0010),
        .phase_err_i(perr), .current_frequency_value_over_limit_i(over), .current_frequency_value_at_limit_i(at), .current_frequency_value_i(current_frequency_value),
        .locked_bw_code_i(5'h14), .acquire_bw_code_i(5'h0F), .loss_of_lock_o(lol),
        .phase_locked_o(lkd), .lock_alarm_o(alarm), .bw_hz_o(bw), .detector_o(det),
        .mc_detector_en_o(mcen), .loop_phase_o(lphase), .integral_freeze_o(frz), .current_frequency_value_read_o(fread));

    initial forever #5 clk = ~clk;

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one-cycle strobes, with an idle edge so the next call never re-drives req in the same step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        check(what, {16'h0000, exp}, {16'h0000, rdata});
    endtask : rd
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        foreach (ra[i]) rd(ra[i], rv[i], "reset value");
        wr(8'h76, 8'hFF);
        rd(8'h76, 8'hE3, "bw reg mask");
        wr(8'h76, 8'hC0);
        wr(8'h79, 8'hA5);
        rd(8'h79, 8'h25, "phase window");
        wr(8'h77, 8'hFF);
        rd(8'h77, 8'h00, "unmapped");
        check("acquire bw", 9'h012, bw);
        check("detector", DET_NEAREST_PD, det);
        wr(8'h75, 8'h71);
        @(posedge clk);
        check("half-cycle pfd", DET_NEAREST_PFD, det);
        wr(8'h75, 8'h73);
        @(posedge clk);
        check("nearest skipped", DET_FULL_PFD, det);
        wr(8'h75, 8'h70);
        check("instant current_frequency_value", 24'h000123, fread);
        run <= 1'b1;
        new_ref <= 1'b1;
        @(posedge clk);
        new_ref <= 1'b0;
        n = 0;
        while (lkd !== 1'b1 && n < 700) begin
            @(posedge clk);
            n++;
        end
        check("lock time", 1'b1, n >= 500 && n < 700);
        rd(8'h7A, 8'hB2, "lock bit");
        check("locked bw", 9'h190, bw);
        perr <= 24'sh000300;
        repeat (3) @(posedge clk);
        check("fine unlock", 2'b01, {lkd, lol});
        check("full pfd", DET_FULL_PFD, det);
        check("one cycle clamp", 24'h000100, lphase);
        wr(8'h75, 8'h5C);
        @(posedge clk);
        check("coarse range", 24'h000300, lphase);
        check("mc detector", 2'b10, {mcen, lol});
        perr <= 24'sh004000;
        repeat (3) @(posedge clk);
        check("coarse unlock", 1'b1, lol);
        check("coarse clamp", 24'h003F00, lphase);
        perr <= '0;
        over <= 1'b1;
        repeat (3) @(posedge clk);
        check("limit unlock", 1'b1, lol);
        wr(8'h75, 8'h1C);
        repeat (2) @(posedge clk);
        check("limit ignored", 1'b0, lol);
        wr(8'h75, 8'h9C);
        run <= 1'b0;
        repeat (40) @(posedge clk);
        check("no activity", 1'b1, lol);
        at <= 1'b1;
        current_frequency_value <= 24'sh000456;
        repeat (3) @(posedge clk);
        check("freeze", 1'b1, frz);
        check("frozen current_frequency_value", 24'h000123, fread);
        // a full averaging second of the new value, bandwidth fixed to locked code
        at <= 1'b0;
        wr(8'h76, 8'h01);
        repeat (520) @(posedge clk);
        check("average current_frequency_value", 24'h000456, fread);
        check("fixed bw", 9'h190, bw);
        // two-second timeout, long since expired while unlocked
        wr(8'h7A, 8'h01);
        n = 0;
        while (alarm !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        check("lock timeout alarm", 1'b1, alarm);
        wr(8'h7A, 8'h00);
        @(posedge clk);
        check("timeout disabled", 1'b0, alarm);
        close_out();
    end

    // watchdog, about three times the expected run
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        close_out();
    end
endmodule : dpll_lock_detect_config_tb

//--- dpllc_cfg_regs.sv
// dpllc_cfg_regs: the four configuration registers with a registered read port.
// assumes single-cycle write and read strobes on the documented register port.
`timescale 1ns/1ns
module dpllc_cfg_regs
    import dpllc_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire dpllc_req_t req_i,
    input  wire logic       phase_locked_i,
    output dpllc_cfg_t      cfg_o,
    output logic [7:0]      rdata_o
);
    dpllc_cfg_t cfg_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    wire        wr_src = req_i.wr && (req_i.addr == ADDR_LOCK_LOSS_SRC);
    wire        wr_bw  = req_i.wr && (req_i.addr == ADDR_LOOP_BW_RB);
    wire        wr_win = req_i.wr && (req_i.addr == ADDR_PHASE_WINDOW);
    wire        wr_tmo = req_i.wr && (req_i.addr == ADDR_LOCK_TIMEOUT);
    wire [7:0]  tmo_rd;

    // top bit of the timeout register reports the live phase-lock state
    assign tmo_rd = {phase_locked_i, cfg_reg.phase_lock_timeout_setting[6:0]};

    // read mux; unmapped addresses and reserved bits read zero
    always_comb begin
        case (req_i.addr)
            ADDR_LOCK_LOSS_SRC: rdata_next = cfg_reg.lock_loss_source_config;
            ADDR_LOOP_BW_RB:    rdata_next = cfg_reg.loop_bandwidth_readback_config;
            ADDR_PHASE_WINDOW:  rdata_next = cfg_reg.phase_window_limits;
            ADDR_LOCK_TIMEOUT:  rdata_next = tmo_rd;
            default:            rdata_next = 8'h00;
        endcase
    end

    // register writes, masked so reserved bits stay zero
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            cfg_reg <= {RST_LOCK_LOSS_SRC, RST_LOOP_BW_RB, RST_PHASE_WINDOW, RST_LOCK_TIMEOUT};
        end else begin
            if (wr_src) cfg_reg.lock_loss_source_config        <= req_i.wdata;
            if (wr_bw)  cfg_reg.loop_bandwidth_readback_config <= req_i.wdata & MASK_LOOP_BW_RB;
            if (wr_win) cfg_reg.phase_window_limits            <= req_i.wdata & MASK_PHASE_WINDOW;
            if (wr_tmo) cfg_reg.phase_lock_timeout_setting     <= req_i.wdata & MASK_LOCK_TIMEOUT;
        end
    end

    // read data held until the next read
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rdata_reg <= 8'h00;
        end else if (req_i.rd) begin
            rdata_reg <= rdata_next;
        end
    end

    assign cfg_o   = cfg_reg;
    assign rdata_o = rdata_reg;
endmodule : dpllc_cfg_regs

//--- dpllc_lock_detect.sv
// dpllc_lock_detect: lock detection and loop configuration of the digital pll.
// assumes phase error, frequency and limit flags come from the loop core each cycle,
// and that ref_edge_i pulses once per reference period.
// How it works
// RULE1 - bandwidth codes 01101..10100 give 4..400 hz; default 4 hz
// RULE2 - no-activity enable set: missing edges unlock, then full phase/frequency locking
// RULE3 - no-activity enable clear: no unlock, nearest-edge locking on return
// RULE4 - frequency beyond hard limit unlocks only while its enable is set
// RULE5 - fine check enabled: phase outside fine window unlocks
// RULE6 - coarse check enabled: phase beyond coarse range unlocks
// RULE7 - multicycle detector enable activates detector with coarse range
// RULE8 - loop measurement clamped to one cycle, or coarse range when multicycle used
// RULE9 - software sets detector enable whenever the loop uses multicycle
// RULE10 - nearest-edge first two seconds, then full locking if unlocked
// RULE11 - nearest-edge disable skips straight to full locking
// RULE12 - detector select chooses pd or pfd, ignored when nearest-edge disabled
// RULE13 - auto bandwidth: acquire bandwidth while acquiring, locked bandwidth once locked
// RULE14 - integral freeze at frequency limit also freezes frequency readback
// RULE15 - software clears bit 5 of bandwidth register for proper operation
// RULE16 - read average 00 instantaneous, 01 one-second average
// RULE17 - lock after two seconds inside fine window, unlock at once outside
// RULE18 - fine code 000 never locks, 001 90, 010 180 degrees, wider above
// RULE19 - coarse code n gives plus/minus 2^(n+1)-1 ui, capped at 8191
// RULE20 - timeout multiplier gives 2, 4, 8 or 16 second resolution; bit 7 is masked to zero, so only 2 or 4 are reachable
// RULE21 - software uses multicycle detector for jitter beyond half ui
// RULE22 - software disables fine check when multi-ui jitter is needed
// RULE23 - timeout is count times 2^(mult+1) seconds; zero disables the alarm
// RULE24 - loss of lock is the or of all enabled sources
`timescale 1ns/1ns
module dpllc_lock_detect
    import dpllc_pkg::*;
#(
    parameter int unsigned SUB_CYC = SUB_CYCLES
) (
    input  wire logic               core_clk_i,
    input  wire logic               rst_b_i,
    input  wire dpllc_req_t         reg_req_i,
    output logic [7:0]              reg_rdata_o,
    input  wire logic               new_ref_i,
    input  wire logic               ref_edge_i,
    input  wire logic [15:0]        ref_period_cyc_i,
    input  wire logic signed [23:0] phase_err_i,
    input  wire logic               current_frequency_value_over_limit_i,
    input  wire logic               current_frequency_value_at_limit_i,
    input  wire logic signed [23:0] current_frequency_value_i,
    input  wire logic [4:0]         locked_bw_code_i,
    input  wire logic [4:0]         acquire_bw_code_i,
    output logic                    loss_of_lock_o,
    output logic                    phase_locked_o,
    output logic                    lock_alarm_o,
    output logic [8:0]              bw_hz_o,
    output dpllc_det_t              detector_o,
    output logic                    mc_detector_en_o,
    output logic signed [23:0]      loop_phase_o,
    output logic                    integral_freeze_o,
    output logic signed [23:0]      current_frequency_value_read_o
);
    typedef enum logic [1:0] {ST_NEAREST, ST_FULL, ST_LOCKED} dpllc_state_t;

    dpllc_cfg_t   cfg;
    dpllc_state_t state_reg, state_next;
    logic [SUB_W-1:0] sub_cnt_reg;
    logic [5:0]   tick_cnt_reg;
    logic [7:0]   stage_cnt_reg, qual_cnt_reg;
    logic [10:0]  sec_cnt_reg;
    logic [16:0]  gap_cnt_reg;
    logic         idle_reg, alarm_reg, lol_reg, frz_reg, lkd_reg;
    logic [29:0]  acc_reg;
    logic signed [23:0] avg_reg, fread_reg, lphase_reg;
    logic [8:0]   bw_reg;
    dpllc_det_t   det_reg;
    logic [8:0]   bw_lut [32];

    // field decode
    wire       na_en   = cfg.lock_loss_source_config[NO_ACTIVITY_UNLOCK_BIT];
    wire       fl_en   = cfg.lock_loss_source_config[CURRENT_FREQUENCY_VALUE_LIMIT_UNLOCK_BIT];
    wire       fine_en = cfg.lock_loss_source_config[FINE_CHECK_BIT];
    wire       crs_en  = cfg.lock_loss_source_config[COARSE_CHECK_BIT];
    wire       mc_en   = cfg.lock_loss_source_config[MC_DETECTOR_BIT];
    wire       use_mc  = cfg.lock_loss_source_config[LOOP_USES_MC_BIT];
    wire       ne_dis  = cfg.lock_loss_source_config[NEAREST_DISABLE_BIT];
    wire       hc_sel  = cfg.lock_loss_source_config[HALF_CYCLE_SEL_BIT];
    wire       auto_bw = cfg.loop_bandwidth_readback_config[AUTO_BW_BIT];
    wire       frz_en  = cfg.loop_bandwidth_readback_config[INTEGRAL_FREEZE_BIT];
    wire [1:0] rd_avg  = cfg.loop_bandwidth_readback_config[READ_AVG_LSB +: 2];
    wire [2:0] fine_cd = cfg.phase_window_limits[FINE_CODE_LSB +: 3];
    wire [3:0] crs_cd  = cfg.phase_window_limits[COARSE_CODE_LSB +: 4];
    wire [1:0] tmo_m   = cfg.phase_lock_timeout_setting[TIMEOUT_MULT_LSB +: 2];
    wire [5:0] tmo_c   = cfg.phase_lock_timeout_setting[TIMEOUT_COUNT_LSB +: 6];

    dpllc_cfg_regs u_regs (
        .core_clk_i     (core_clk_i),
        .rst_b_i        (rst_b_i),
        .req_i          (reg_req_i),
        .phase_locked_i (state_reg == ST_LOCKED),
        .cfg_o          (cfg),
        .rdata_o        (reg_rdata_o)
    );

    // time base: 64 subticks per second keeps the second-scale counters narrow
    wire sub_tick = (sub_cnt_reg == SUB_W'(SUB_CYC - 1));
    wire sec_tick = sub_tick && (tick_cnt_reg == 6'h3F);

    // phase magnitude and window limits in 1/256 ui
    wire [23:0] ph_abs   = phase_err_i[23] ? 24'(-phase_err_i) : phase_err_i;
    wire [3:0]  crs_n    = (crs_cd > COARSE_CODE_TOP) ? (COARSE_CODE_TOP + 4'h1) : crs_cd; // see RULE19
    wire [23:0] crs_ui   = 24'((24'h000002 << crs_n) - 24'h000001);                       // see RULE19
    wire [23:0] crs_lim  = 24'(crs_ui << 8);
    wire [23:0] fine_lim = 24'(QUARTER_UI * fine_cd);                                     // see RULE18
    wire        in_fine  = (fine_cd != 3'h0) && (ph_abs <= fine_lim);                     // see RULE18
    wire [23:0] meas_lim = use_mc ? crs_lim : ONE_UI;                                     // see RULE8

    // loss-of-lock sources
    wire no_act   = (gap_cnt_reg > 17'(ref_period_cyc_i) * 17'(NOACT_PERIODS));
    wire src_na   = na_en && no_act;                        // see RULE2
    wire src_fl   = fl_en && current_frequency_value_over_limit_i;             // see RULE4
    wire src_fine = fine_en && !in_fine;                    // see RULE5
    wire src_crs  = crs_en && (ph_abs > crs_lim);           // see RULE6
    wire lol_now  = src_na || src_fl || src_fine || src_crs; // see RULE24
    wire returned = idle_reg && ref_edge_i;
    // a new reference, or a returning one while the no-activity enable is clear, restarts the acquisition stages
    wire restart  = new_ref_i || (returned && !na_en);                  // see RULE3
    wire qualified = (qual_cnt_reg >= QUALIFY_SUBTICKS);
    wire [10:0] tmo_sec = 11'({5'h00, tmo_c} << (3'(tmo_m) + 3'h1)); // see RULE20

    // acquisition state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_NEAREST: begin
                if (src_na || ne_dis) state_next = ST_FULL;                           // see RULE11
                else if (qualified && !lol_now) state_next = ST_LOCKED;
                else if (stage_cnt_reg >= NEAREST_SUBTICKS) state_next = ST_FULL;     // see RULE10
            end
            ST_FULL: begin
                if (qualified && !lol_now) state_next = ST_LOCKED;
            end
            ST_LOCKED: begin
                if (lol_now) state_next = ST_FULL;                                     // see RULE17
            end
            default: state_next = ST_FULL;
        endcase
        if (restart) begin                                                             // see RULE3
            state_next = ne_dis ? ST_FULL : ST_NEAREST;
        end
    end

    // state and second-scale counters
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state_reg     <= ST_NEAREST;
            sub_cnt_reg   <= '0;
            tick_cnt_reg  <= 6'h00;
            stage_cnt_reg <= 8'h00;
            qual_cnt_reg  <= 8'h00;
            sec_cnt_reg   <= 11'h000;
        end else begin
            state_reg    <= state_next;
            sub_cnt_reg  <= sub_tick ? '0 : SUB_W'(sub_cnt_reg + 1'b1);
            tick_cnt_reg <= sub_tick ? 6'(tick_cnt_reg + 6'h01) : tick_cnt_reg;
            if (state_next != state_reg || restart) stage_cnt_reg <= 8'h00;          // see RULE10
            else if (sub_tick && stage_cnt_reg != 8'hFF) stage_cnt_reg <= 8'(stage_cnt_reg + 8'h01);
            if (!in_fine || new_ref_i) qual_cnt_reg <= 8'h00;                         // see RULE17
            else if (sub_tick && !qualified) qual_cnt_reg <= 8'(qual_cnt_reg + 8'h01);
            if (new_ref_i || state_reg == ST_LOCKED) sec_cnt_reg <= 11'h000;
            else if (sec_tick && sec_cnt_reg != 11'h7FF) sec_cnt_reg <= 11'(sec_cnt_reg + 11'h001);
        end
    end

    // reference activity watch, restarted by every edge
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            gap_cnt_reg <= 17'h00000;
            idle_reg    <= 1'b0;
        end else begin
            gap_cnt_reg <= ref_edge_i ? 17'h00000 : (gap_cnt_reg == 17'h1FFFF ? gap_cnt_reg : 17'(gap_cnt_reg + 1'b1));
            idle_reg    <= ref_edge_i ? 1'b0 : (idle_reg || no_act);
        end
    end

    // timeout alarm: a zero count never raises it
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            alarm_reg <= 1'b0;
        end else if (new_ref_i || state_reg == ST_LOCKED || tmo_c == 6'h00) begin
            alarm_reg <= 1'b0;
        end else if (sec_cnt_reg >= tmo_sec) begin
            alarm_reg <= 1'b1;                                                        // see RULE23
        end
    end

    // bandwidth lookup built once; unused codes fall back to the default
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_bw
            localparam logic [8:0] HZ = (gi == 13) ? 9'h004 : (gi == 14) ? 9'h008 : (gi == 15) ? 9'h012 :
                                        (gi == 16) ? 9'h023 : (gi == 17) ? 9'h046 : (gi == 18) ? 9'h078 :
                                        (gi == 19) ? 9'h0FA : (gi == 20) ? 9'h190 : BW_DEFAULT_HZ;
            assign bw_lut[gi] = HZ;                                                   // see RULE1
        end
    endgenerate
    wire [4:0] bw_code = (auto_bw && state_reg != ST_LOCKED) ? acquire_bw_code_i : locked_bw_code_i; // see RULE13

    // detector choice and clamped loop measurement
    wire dpllc_det_t det_next = (state_reg == ST_NEAREST && !ne_dis) ?
                                (hc_sel ? DET_NEAREST_PFD : DET_NEAREST_PD) : DET_FULL_PFD;           // see RULE12
    wire signed [23:0] ph_clamp = (ph_abs <= meas_lim) ? phase_err_i :
                                  (phase_err_i[23] ? 24'(-meas_lim) : meas_lim);                       // see RULE8

    // one-second frequency average over 64 evenly spaced samples
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            acc_reg <= 30'h00000000;
            avg_reg <= 24'h000000;
        end else if (sec_tick) begin
            acc_reg <= 30'h00000000;
            avg_reg <= 24'((acc_reg + 30'(current_frequency_value_i)) >> 6);
        end else if (sub_tick) begin
            acc_reg <= 30'(acc_reg + 30'(current_frequency_value_i));
        end
    end

    // registered outputs
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            lol_reg    <= 1'b0;
            lkd_reg    <= 1'b0;
            frz_reg    <= 1'b0;
            fread_reg  <= 24'h000000;
            lphase_reg <= 24'h000000;
            bw_reg     <= BW_DEFAULT_HZ;
            det_reg    <= DET_NEAREST_PD;
        end else begin
            lol_reg    <= lol_now;
            lkd_reg    <= (state_next == ST_LOCKED);
            frz_reg    <= frz_en && current_frequency_value_at_limit_i;                                  // see RULE14
            if (!(frz_en && current_frequency_value_at_limit_i))                                          // see RULE14
                fread_reg <= (rd_avg == READ_AVERAGE) ? avg_reg : current_frequency_value_i;             // see RULE16
            lphase_reg <= ph_clamp;
            bw_reg     <= (bw_code >= BW_CODE_MIN && bw_code <= BW_CODE_MAX) ? bw_lut[bw_code] : BW_DEFAULT_HZ;
            det_reg    <= det_next;
        end
    end

    assign loss_of_lock_o    = lol_reg;
    assign phase_locked_o    = lkd_reg;
    assign lock_alarm_o      = alarm_reg;
    assign bw_hz_o           = bw_reg;
    assign detector_o        = det_reg;
    assign mc_detector_en_o  = mc_en;                                                  // see RULE7
    assign loop_phase_o      = lphase_reg;
    assign integral_freeze_o = frz_reg;
    assign current_frequency_value_read_o       = fread_reg;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_lol_or;
        lol_now |=> loss_of_lock_o;
    endproperty
    a_lol_or: assert property (p_lol_or) else $error("loss of lock not reported"); // see RULE24

    property p_fl;
        (fl_en && current_frequency_value_over_limit_i) |=> loss_of_lock_o;
    endproperty
    a_fl: assert property (p_fl) else $error("frequency limit did not unlock"); // see RULE4

    property p_fine;
        (state_reg == ST_LOCKED && fine_en && !in_fine) |=> !phase_locked_o;
    endproperty
    a_fine: assert property (p_fine) else $error("fine window exit kept lock"); // see RULE5

    property p_no_lock_code0;
        (fine_cd == 3'h0 && fine_en) |=> loss_of_lock_o;
    endproperty
    a_no_lock_code0: assert property (p_no_lock_code0) else $error("fine code zero saw window"); // see RULE18

    property p_qualify;
        ($rose(state_reg == ST_LOCKED) && !$past(new_ref_i)) |-> $past(qual_cnt_reg) >= QUALIFY_SUBTICKS;
    endproperty
    a_qualify: assert property (p_qualify) else $error("lock declared before qualification"); // see RULE17

    property p_skip_nearest;
        (ne_dis && !new_ref_i) |=> state_reg != ST_NEAREST;
    endproperty
    a_skip_nearest: assert property (p_skip_nearest) else $error("nearest stage used while disabled"); // see RULE11

    property p_clamp;
        (!use_mc && $past(!use_mc)) |-> (loop_phase_o <= $signed(ONE_UI) && loop_phase_o >= -$signed(ONE_UI));
    endproperty
    a_clamp: assert property (p_clamp) else $error("loop phase exceeds one cycle"); // see RULE8

    property p_freeze;
        (frz_en && current_frequency_value_at_limit_i) |=> $stable(current_frequency_value_read_o) && integral_freeze_o;
    endproperty
    a_freeze: assert property (p_freeze) else $error("readback moved while frozen"); // see RULE14

    property p_alarm_zero;
        (tmo_c == 6'h00) |=> !lock_alarm_o;
    endproperty
    a_alarm_zero: assert property (p_alarm_zero) else $error("alarm with timeout disabled"); // see RULE23

    property p_det_full;
        (ne_dis && $past(ne_dis)) |-> detector_o == DET_FULL_PFD;
    endproperty
    a_det_full: assert property (p_det_full) else $error("half-cycle select not ignored"); // see RULE12
endmodule : dpllc_lock_detect

//--- dpllc_pkg.sv
// dpllc_pkg: constants, register map and carrier types for the dpll
// lock-detect configuration block.
// assumes a 100 mhz core clock and 8-bit registers at fixed addresses.
package dpllc_pkg;
    // clock and time base
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned SEC_NS           = 1000000000;
    localparam int unsigned SEC_CYCLES       = SEC_NS / CLK_PERIOD_NS;
    localparam int unsigned SUBTICKS_PER_SEC = 64;
    localparam int unsigned SUB_CYCLES       = SEC_CYCLES / SUBTICKS_PER_SEC;
    localparam int unsigned SUB_W            = 21;
    localparam int unsigned NEAREST_SEC      = 2;
    localparam int unsigned QUALIFY_SEC      = 2;
    localparam logic [7:0]  NEAREST_SUBTICKS = 8'(NEAREST_SEC * SUBTICKS_PER_SEC);
    localparam logic [7:0]  QUALIFY_SUBTICKS = 8'(QUALIFY_SEC * SUBTICKS_PER_SEC);
    localparam int unsigned NOACT_PERIODS    = 2;

    // register addresses
    localparam logic [7:0] ADDR_LOCK_LOSS_SRC = 8'h75;
    localparam logic [7:0] ADDR_LOOP_BW_RB    = 8'h76;
    localparam logic [7:0] ADDR_PHASE_WINDOW  = 8'h79;
    localparam logic [7:0] ADDR_LOCK_TIMEOUT  = 8'h7A;

    // reset values and writable masks
    localparam logic [7:0] RST_LOCK_LOSS_SRC  = 8'h70;
    localparam logic [7:0] RST_LOOP_BW_RB     = 8'hE0;
    localparam logic [7:0] RST_PHASE_WINDOW   = 8'h25;
    localparam logic [7:0] RST_LOCK_TIMEOUT   = 8'h32;
    localparam logic [7:0] MASK_LOOP_BW_RB    = 8'hE3;
    localparam logic [7:0] MASK_PHASE_WINDOW  = 8'h7F;
    localparam logic [7:0] MASK_LOCK_TIMEOUT  = 8'h7F;

    // field positions
    localparam int unsigned NO_ACTIVITY_UNLOCK_BIT = 7;
    localparam int unsigned CURRENT_FREQUENCY_VALUE_LIMIT_UNLOCK_BIT  = 6;
    localparam int unsigned FINE_CHECK_BIT         = 5;
    localparam int unsigned COARSE_CHECK_BIT       = 4;
    localparam int unsigned MC_DETECTOR_BIT        = 3;
    localparam int unsigned LOOP_USES_MC_BIT       = 2;
    localparam int unsigned NEAREST_DISABLE_BIT    = 1;
    localparam int unsigned HALF_CYCLE_SEL_BIT     = 0;
    localparam int unsigned AUTO_BW_BIT            = 7;
    localparam int unsigned INTEGRAL_FREEZE_BIT    = 6;
    localparam int unsigned READ_AVG_LSB           = 0;
    localparam int unsigned FINE_CODE_LSB          = 4;
    localparam int unsigned COARSE_CODE_LSB        = 0;
    localparam int unsigned TIMEOUT_MULT_LSB       = 6;
    localparam int unsigned TIMEOUT_COUNT_LSB      = 0;
    localparam int unsigned TIMEOUT_TOP_BIT        = 7;

    // bandwidth codes, phase units (256 per unit interval)
    localparam logic [4:0]  BW_CODE_MIN     = 5'h0D;
    localparam logic [4:0]  BW_CODE_MAX     = 5'h14;
    localparam logic [8:0]  BW_DEFAULT_HZ   = 9'h004;
    localparam logic [23:0] ONE_UI          = 24'h000100;
    localparam logic [23:0] QUARTER_UI      = 24'h000040;
    localparam logic [3:0]  COARSE_CODE_TOP = 4'hB;
    localparam logic [1:0]  READ_INSTANT    = 2'h0;
    localparam logic [1:0]  READ_AVERAGE    = 2'h1;

    typedef struct packed {
        logic [7:0] lock_loss_source_config;
        logic [7:0] loop_bandwidth_readback_config;
        logic [7:0] phase_window_limits;
        logic [7:0] phase_lock_timeout_setting;
    } dpllc_cfg_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dpllc_req_t;

    typedef enum logic [1:0] {
        DET_NEAREST_PD,
        DET_NEAREST_PFD,
        DET_FULL_PFD
    } dpllc_det_t;
endpackage : dpllc_pkg

//--- dpllc_ref_model.sv
// dpllc_ref_model: reference clock being tracked, one edge pulse per period.
// assumes the bench drives run_i and period_i from the core clock domain.
`timescale 1ns/1ns
module dpllc_ref_model (
    input  wire logic        core_clk_i,
    input  wire logic        run_i,
    input  wire logic [15:0] period_i,
    output logic             ref_edge_o
);
    logic [15:0] cnt_reg = 16'h0000;
    initial ref_edge_o = 1'b0;
    // stopped reference gives no edges at all, so missing cycles are real
    always @(posedge core_clk_i) begin
        cnt_reg    <= (!run_i || cnt_reg >= period_i - 16'h0001) ? 16'h0000 : cnt_reg + 16'h0001;
        ref_edge_o <= run_i && cnt_reg == 16'h0000;
    end
endmodule : dpllc_ref_model
